// ### design/vnss_pkg.sv
// package: states, codes, limits and carriers of the valve node supervisor
package vnss_pkg;
   // Summary of operation
   // - pause to mode_select only without active error
   // - lockout never leads back to safe_idle
   // - invalid request acked, emergency sent, then pause
   // - invalid request leaves node_status_word unchanged
   // - startup to safe_idle needs network Operational
   // - entering startup reloads device parameter defaults
   // - timer 1..29 ms guards 30 ms; zero disables
   // - timer above 250 ms guards 250 ms
   // - layer setting only when stopped; id_bad is sampled before the strap reaches sync stage two
   // - combined update applies mode before control word
   // - transmit PDOs refuse asynchronous cyclic type
   // - emergency id 0x81 code 0x1000 stops network
   // - over-voltage counter up/down, fault at 50
   // - over-voltage clears after net 50 good samples
   // - under-voltage counts below 9 V, symmetric
   // - over-voltage warning code 0x3411, register 0x5
   // - under-voltage warning code 0x3412, register 0x5
   // - illegal state request code 0x5200, register 0x21
   // - fault passes reaction state to pause or lockout

   // node_state_machine states
   typedef enum logic [2:0] {
      ST_STARTUP = 3'h0,
      ST_SAFE_IDLE = 3'h1,
      ST_MODE_SELECT = 3'h2,
      ST_RUNNING = 3'h3,
      ST_FAULT_REACT = 3'h4,
      ST_WARN_PAUSE = 3'h5,
      ST_LOCKOUT = 3'h6
   } vnss_state_t;

   // network management states
   typedef enum logic [1:0] {
      NMT_PREOP = 2'h0,
      NMT_OPER = 2'h1,
      NMT_STOPPED = 2'h2
   } vnss_nmt_t;

   // network management commands
   typedef enum logic [1:0] {
      NCMD_START = 2'h0,
      NCMD_STOP = 2'h1,
      NCMD_PREOP = 2'h2,
      NCMD_RESET_NODE = 2'h3
   } vnss_ncmd_t;

   localparam logic [15:0] EMCY_OV_CODE = 16'h3411; // supply too high
   localparam logic [15:0] EMCY_UV_CODE = 16'h3412; // supply too low
   localparam logic [15:0] EMCY_DSM_CODE = 16'h5200; // illegal state command
   localparam logic [7:0] ERR_REG_SUPPLY = 8'h05; // supply warnings
   localparam logic [7:0] ERR_REG_DSM = 8'h21; // state command warning
   localparam logic [10:0] EMCY_RX_ID = 11'h081; // consumed emergency id
   localparam logic [15:0] EMCY_STOP_CODE = 16'h1000; // forces stopped
   localparam logic [7:0] INVALID_NODE_ID = 8'hFF; // unconfigured id
   localparam logic [7:0] TTYPE_ASYNC_CYC = 8'hFE; // refused type code
   localparam logic [7:0] TTYPE_RESET = 8'h01; // transmit type at reset
   localparam logic [15:0] ET_MIN_MS = 16'h001E; // lowest guard, 30 ms
   localparam logic [15:0] ET_MAX_MS = 16'h00FA; // highest guard, 250 ms
   localparam logic [15:0] OV_LIMIT_MV = 16'h8AAC; // 35500 mV
   localparam logic [15:0] UV_LIMIT_MV = 16'h2328; // 9000 mV
   localparam int FILT_LIMIT = 50; // filter count that raises a fault
   localparam logic [7:0] MODE_DEFAULT = 8'h00; // device mode default
   localparam logic [15:0] CTRL_DEFAULT = 16'h0000; // control default
   localparam int MS_NS = 1000000; // one millisecond in ns
   localparam int CLK_NS = 40; // reference clock period in ns
   localparam int MS_CYCLES = MS_NS / CLK_NS; // cycles per millisecond
   localparam logic [1:0] BOOT_SETTLE = 2'h2; // strap sync depth

   // emergency frame carrier
   typedef struct packed {
      logic [15:0] code;
      logic [7:0] err_reg;
   } vnss_emcy_t;

   // device control receive PDO carrier
   typedef struct packed {
      logic [15:0] ctrl;
      logic [7:0] mode;
   } vnss_pdo_t;
endpackage

// ### design/vnss_vfilt.sv
// saturating up/down sample counter that raises and clears a supply fault
`timescale 1ns/10ps
module vnss_vfilt
   import vnss_pkg::*;
#(
   parameter int LIMIT = FILT_LIMIT
) (
   input wire logic ref_clk, // node clock
   input wire logic arst_n, // async reset, low
   input wire logic sample, // one supply sample
   input wire logic bad, // sample outside limit
   output logic fault // filtered fault level
);
   localparam int CW = $clog2(LIMIT + 1);
   localparam logic [CW-1:0] TOP = CW'(LIMIT);

   initial begin
      if (LIMIT < 2) $error("vnss_vfilt: LIMIT below 2");
   end

   // counter and fault flag
   typedef struct packed {
      logic [CW-1:0] cnt;
      logic flt;
   } vnss_vf_t;

   vnss_vf_t r_reg; // registered state
   vnss_vf_t r_next; // next state

   // count and hysteresis
   always_comb begin
      r_next = r_reg;
      if (sample) begin
         if (bad && r_reg.cnt != TOP) begin
            r_next.cnt = r_reg.cnt + 1'b1;
         end else if (!bad && r_reg.cnt != '0) begin
            r_next.cnt = r_reg.cnt - 1'b1;
         end
      end
      if (r_next.cnt == TOP) begin
         r_next.flt = 1'b1;
      end else if (r_next.cnt == '0) begin
         r_next.flt = 1'b0;
      end
   end

   // state register
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         r_reg <= '0;
      end else begin
         r_reg <= r_next;
      end
   end

   assign fault = r_reg.flt;
endmodule

// ### design/vnss_top.sv
// valve node supervisor: node state machine, guards, filters, emergencies
`timescale 1ns/10ps
module vnss_top
   import vnss_pkg::*;
#(
   parameter int MS_CYC = MS_CYCLES, // cycles per millisecond
   parameter int FLT_LIM = FILT_LIMIT // supply filter threshold
) (
   input wire logic REF_CLK, // 25 MHz node clock
   input wire logic ARST_N, // async reset, low
   input wire logic STATE_REQ_VALID, // state change write strobe
   input wire vnss_state_t STATE_REQ, // requested state
   output logic STATE_REQ_ACK, // write answered as success
   output logic [15:0] NODE_STATUS_WORD, // node_status_word object
   output vnss_state_t NODE_STATE, // node_state_machine state
   input wire logic NMT_CMD_VALID, // network command strobe
   input wire vnss_ncmd_t NMT_CMD, // network command
   output vnss_nmt_t NMT_STATE, // network state
   input wire logic [7:0] NODE_ID_PIN, // own node id strap
   input wire logic LSS_CMD_VALID, // layer-setting command strobe
   output logic LSS_ACCEPT, // command taken for processing
   output logic LSS_REJECT, // command ignored
   input wire logic PDO_VALID, // device control PDO strobe
   input wire vnss_pdo_t PDO_DATA, // control word and mode
   output logic [7:0] MODE_OUT, // device mode in force
   output logic [15:0] CTRL_OUT, // control word in force
   input wire logic TTYPE_VALID, // transmit type write strobe
   input wire logic [7:0] TTYPE_VALUE, // requested transmit type
   output logic [7:0] TTYPE_OUT, // transmit type in force
   output logic TTYPE_REJECT, // write refused
   input wire logic ET_VALID, // event timer write strobe
   input wire logic [15:0] ET_VALUE, // event timer in ms
   output logic GUARD_EN, // time guarding active
   output logic [15:0] GUARD_MS, // guard timeout in ms
   input wire logic RPDO_RX, // guarded PDO received
   output logic GUARD_TIMEOUT, // guarded PDO overdue
   input wire logic EMCY_RX_VALID, // received emergency strobe
   input wire logic [10:0] EMCY_RX_COBID, // its identifier
   input wire logic [15:0] EMCY_RX_CODE, // its error code
   input wire logic SUPPLY_SAMPLE, // supply sample strobe
   input wire logic [15:0] SUPPLY_A_MV, // supply input a, mV
   input wire logic [15:0] SUPPLY_B_MV, // supply_input_b, mV
   output logic OV_FAULT, // over-voltage fault
   output logic UV_FAULT, // under-voltage fault
   input wire logic CRIT_FAULT, // critical or severe fault
   output logic DEFAULTS_RELOAD, // reload device parameters
   output logic EMCY_TX_VALID, // emergency frame strobe
   output vnss_emcy_t EMCY_TX // emergency frame content
);
   localparam int TW = $clog2(MS_CYC + 1);
   localparam logic [TW-1:0] TICK_END = TW'(MS_CYC - 1);

   initial begin
      if (MS_CYC < 1) $error("vnss_top: MS_CYC below 1");
      if (FLT_LIM < 2) $error("vnss_top: FLT_LIM below 2");
   end

   // all registered state
   typedef struct packed {
      vnss_state_t st; // node state
      vnss_nmt_t nmt; // network state
      logic [15:0] sw; // status word
      logic sw_hold; // status frozen after bad request
      logic ack; // write answer
      logic reload; // defaults reload pulse
      logic [7:0] mode; // mode in force
      logic [15:0] ctrl; // control in force
      logic ctrl_pend; // control waits one cycle
      logic [15:0] ctrl_new; // waiting control word
      logic [7:0] ttype; // transmit type
      logic ttype_rej; // refusal pulse
      logic [15:0] gms; // guard timeout
      logic [TW-1:0] tick; // ms prescaler
      logic [15:0] elapsed; // ms since last PDO
      logic armed; // guard running
      logic gto; // timeout pulse
      logic [2:0] pend; // emergencies waiting
      logic etx_v; // emergency strobe
      vnss_emcy_t etx; // emergency content
      logic lss_acc; // layer-setting accept
      logic lss_rej; // layer-setting reject
      logic [7:0] id_meta; // strap sync stage one
      logic [7:0] id_sync; // strap sync stage two
      logic [1:0] boot_cnt; // strap settle count
      logic id_bad; // sync stage two invalid while settle count runs
      logic ov_d; // previous over-voltage
      logic uv_d; // previous under-voltage
   } vnss_st_t;

   vnss_st_t r_reg; // registered state
   vnss_st_t r_next; // next state

   logic ov_bad; // this sample over limit
   logic uv_bad; // this sample under limit
   logic ov_flt; // filtered over-voltage
   logic uv_flt; // filtered under-voltage
   logic err_active; // any error present
   logic req_ok; // request is a legal move
   logic bad_req; // request refused
   logic [2:0] ev_new; // new emergency events
   logic [2:0] ev_sent; // emergency sent now

   assign ov_bad = (SUPPLY_A_MV > OV_LIMIT_MV) || (SUPPLY_B_MV > OV_LIMIT_MV);
   assign uv_bad = (SUPPLY_A_MV < UV_LIMIT_MV) || (SUPPLY_B_MV < UV_LIMIT_MV);

   // over-voltage filter
   vnss_vfilt #(
      .LIMIT(FLT_LIM)
   ) u_ov (
      .ref_clk(REF_CLK),
      .arst_n(ARST_N),
      .sample(SUPPLY_SAMPLE),
      .bad(ov_bad),
      .fault(ov_flt)
   );

   // under-voltage filter
   vnss_vfilt #(
      .LIMIT(FLT_LIM)
   ) u_uv (
      .ref_clk(REF_CLK),
      .arst_n(ARST_N),
      .sample(SUPPLY_SAMPLE),
      .bad(uv_bad),
      .fault(uv_flt)
   );

   assign err_active = ov_flt || uv_flt || CRIT_FAULT;

   // legal moves of the node state machine
   always_comb begin
      req_ok = 1'b0;
      case (r_reg.st)
         ST_STARTUP: req_ok = (STATE_REQ == ST_SAFE_IDLE) && (r_reg.nmt == NMT_OPER);
         ST_SAFE_IDLE: req_ok = (STATE_REQ == ST_MODE_SELECT);
         ST_MODE_SELECT: req_ok = (STATE_REQ == ST_RUNNING) || (STATE_REQ == ST_SAFE_IDLE);
         ST_RUNNING: req_ok = (STATE_REQ == ST_MODE_SELECT) || (STATE_REQ == ST_SAFE_IDLE);
         ST_WARN_PAUSE: req_ok = (STATE_REQ == ST_MODE_SELECT) && !err_active;
         ST_LOCKOUT: req_ok = 1'b0;
         default: req_ok = 1'b0;
      endcase
   end

   assign bad_req = STATE_REQ_VALID && !req_ok;
   assign ev_new = {uv_flt && !r_reg.uv_d, ov_flt && !r_reg.ov_d, bad_req};

   // one emergency per cycle, state command first
   always_comb begin
      ev_sent = 3'h0;
      if (r_reg.pend[0]) begin
         ev_sent = 3'h1;
      end else if (r_reg.pend[1]) begin
         ev_sent = 3'h2;
      end else if (r_reg.pend[2]) begin
         ev_sent = 3'h4;
      end
   end

   // next state of everything
   always_comb begin
      r_next = r_reg;
      r_next.ack = STATE_REQ_VALID;
      r_next.ttype_rej = 1'b0;
      r_next.gto = 1'b0;
      r_next.lss_acc = 1'b0;
      r_next.lss_rej = 1'b0;
      r_next.etx_v = 1'b0;
      r_next.ov_d = ov_flt;
      r_next.uv_d = uv_flt;
      // strap sync; id_bad sampled from sync stage two while the settle count runs
      r_next.id_meta = NODE_ID_PIN;
      r_next.id_sync = r_reg.id_meta;
      if (r_reg.boot_cnt != BOOT_SETTLE) begin
         r_next.boot_cnt = r_reg.boot_cnt + 2'h1;
         r_next.id_bad = (r_reg.id_sync == INVALID_NODE_ID);
      end
      // network management
      if (NMT_CMD_VALID) begin
         case (NMT_CMD)
            NCMD_START: r_next.nmt = NMT_OPER;
            NCMD_STOP: r_next.nmt = NMT_STOPPED;
            NCMD_PREOP: r_next.nmt = NMT_PREOP;
            NCMD_RESET_NODE: r_next.nmt = NMT_PREOP;
            default: r_next.nmt = r_reg.nmt;
         endcase
      end
      if (EMCY_RX_VALID && EMCY_RX_COBID == EMCY_RX_ID && EMCY_RX_CODE == EMCY_STOP_CODE) begin
         r_next.nmt = NMT_STOPPED;
      end
      // layer-setting gate
      if (LSS_CMD_VALID) begin
         if (r_reg.nmt == NMT_STOPPED || r_reg.id_bad) begin
            r_next.lss_acc = 1'b1;
         end else begin
            r_next.lss_rej = 1'b1;
         end
      end
      // node state machine
      case (r_reg.st)
         ST_LOCKOUT: r_next.st = ST_LOCKOUT;
         ST_FAULT_REACT: r_next.st = CRIT_FAULT ? ST_LOCKOUT : ST_WARN_PAUSE;
         default: begin
            if (CRIT_FAULT || bad_req || ev_new[1] || ev_new[2]) begin
               r_next.st = ST_FAULT_REACT;
            end else if (STATE_REQ_VALID) begin
               r_next.st = STATE_REQ;
            end
         end
      endcase
      if (NMT_CMD_VALID && NMT_CMD == NCMD_RESET_NODE && r_reg.st != ST_LOCKOUT) begin
         r_next.st = ST_STARTUP;
      end
      // status word follows the state except after a refused request
      if (bad_req) begin
         r_next.sw_hold = 1'b1;
      end else if (STATE_REQ_VALID || r_next.st == ST_STARTUP) begin
         r_next.sw_hold = 1'b0;
      end
      if (!r_next.sw_hold) begin
         r_next.sw = {13'h0000, r_next.st};
      end
      r_next.reload = (r_next.st == ST_STARTUP) && (r_reg.st != ST_STARTUP);
      // mode at once, control word one cycle later
      if (r_reg.ctrl_pend) begin
         r_next.ctrl = r_reg.ctrl_new;
         r_next.ctrl_pend = 1'b0;
      end
      if (PDO_VALID) begin
         r_next.mode = PDO_DATA.mode;
         r_next.ctrl_new = PDO_DATA.ctrl;
         r_next.ctrl_pend = 1'b1;
      end
      if (r_next.reload) begin
         r_next.mode = MODE_DEFAULT;
         r_next.ctrl = CTRL_DEFAULT;
         r_next.ctrl_pend = 1'b0;
      end
      // transmit type
      if (TTYPE_VALID) begin
         if (TTYPE_VALUE == TTYPE_ASYNC_CYC) begin
            r_next.ttype_rej = 1'b1;
         end else begin
            r_next.ttype = TTYPE_VALUE;
         end
      end
      // event timer clamp
      if (ET_VALID) begin
         if (ET_VALUE == 16'h0000) begin
            r_next.gms = 16'h0000;
         end else if (ET_VALUE < ET_MIN_MS) begin
            r_next.gms = ET_MIN_MS;
         end else if (ET_VALUE > ET_MAX_MS) begin
            r_next.gms = ET_MAX_MS;
         end else begin
            r_next.gms = ET_VALUE;
         end
      end
      // guard timer
      r_next.tick = (r_reg.tick == TICK_END) ? '0 : r_reg.tick + 1'b1;
      if (r_reg.armed && r_reg.tick == TICK_END) begin
         r_next.elapsed = r_reg.elapsed + 16'h0001;
         if (r_next.elapsed >= r_reg.gms) begin
            r_next.gto = 1'b1;
            r_next.armed = 1'b0;
         end
      end
      if (RPDO_RX || ET_VALID) begin
         r_next.tick = '0;
         r_next.elapsed = 16'h0000;
         r_next.armed = RPDO_RX && (r_next.gms != 16'h0000);
      end
      if (r_next.gms == 16'h0000) begin
         r_next.armed = 1'b0;
      end
      // emergency queue, a new event wins over its own clear
      r_next.pend = (r_reg.pend & ~ev_sent) | ev_new;
      if (ev_sent != 3'h0) begin
         r_next.etx_v = 1'b1;
      end
      case (ev_sent)
         3'h1: r_next.etx = '{code: EMCY_DSM_CODE, err_reg: ERR_REG_DSM};
         3'h2: r_next.etx = '{code: EMCY_OV_CODE, err_reg: ERR_REG_SUPPLY};
         3'h4: r_next.etx = '{code: EMCY_UV_CODE, err_reg: ERR_REG_SUPPLY};
         default: r_next.etx = r_reg.etx;
      endcase
   end

   // state register
   always_ff @(posedge REF_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         r_reg <= '0;
         r_reg.reload <= 1'b1;
         r_reg.ttype <= TTYPE_RESET;
      end else begin
         r_reg <= r_next;
      end
   end

   assign STATE_REQ_ACK = r_reg.ack;
   assign NODE_STATUS_WORD = r_reg.sw;
   assign NODE_STATE = r_reg.st;
   assign NMT_STATE = r_reg.nmt;
   assign LSS_ACCEPT = r_reg.lss_acc;
   assign LSS_REJECT = r_reg.lss_rej;
   assign MODE_OUT = r_reg.mode;
   assign CTRL_OUT = r_reg.ctrl;
   assign TTYPE_OUT = r_reg.ttype;
   assign TTYPE_REJECT = r_reg.ttype_rej;
   assign GUARD_EN = (r_reg.gms != 16'h0000);
   assign GUARD_MS = r_reg.gms;
   assign GUARD_TIMEOUT = r_reg.gto;
   assign OV_FAULT = ov_flt;
   assign UV_FAULT = uv_flt;
   assign DEFAULTS_RELOAD = r_reg.reload;
   assign EMCY_TX_VALID = r_reg.etx_v;
   assign EMCY_TX = r_reg.etx;

   // checks on the design's own outputs
   default clocking cb @(posedge REF_CLK);
   endclocking
   default disable iff (!ARST_N);

   sequence s_bad_req;
      bad_req && !CRIT_FAULT && r_reg.st != ST_LOCKOUT && r_reg.st != ST_FAULT_REACT;
   endsequence

   sequence s_react_pause;
      r_reg.st == ST_FAULT_REACT ##1 r_reg.st == ST_WARN_PAUSE;
   endsequence

   a_pause_exit_clean: assert property (
      r_reg.st == ST_WARN_PAUSE ##1 r_reg.st == ST_MODE_SELECT |-> !$past(err_active))
      else $error("left pause with an error active");

   a_lockout_holds: assert property (
      r_reg.st == ST_LOCKOUT |=> r_reg.st == ST_LOCKOUT)
      else $error("left lockout");

   a_bad_req_path: assert property (
      s_bad_req ##0 !ev_new[1] ##0 !ev_new[2] ##1 !CRIT_FAULT |-> STATE_REQ_ACK
      ##0 s_react_pause)
      else $error("refused request not acked and paused");

   a_status_frozen: assert property (
      s_bad_req |=> $stable(NODE_STATUS_WORD) [*2])
      else $error("status word changed after refused request");

   a_start_needs_oper: assert property (
      r_reg.st == ST_STARTUP ##1 r_reg.st == ST_SAFE_IDLE |-> $past(r_reg.nmt) == NMT_OPER)
      else $error("safe_idle reached without operational network");

   a_reload_on_entry: assert property (
      r_reg.st != ST_STARTUP ##1 r_reg.st == ST_STARTUP |-> DEFAULTS_RELOAD)
      else $error("no defaults reload on startup entry");

   a_guard_range: assert property (
      GUARD_EN |-> GUARD_MS >= ET_MIN_MS && GUARD_MS <= ET_MAX_MS)
      else $error("guard timeout outside clamp");

   a_lss_gate: assert property (
      LSS_ACCEPT |-> $past(r_reg.nmt) == NMT_STOPPED || $past(r_reg.id_bad))
      else $error("layer setting taken when not allowed");

   a_mode_first: assert property (
      PDO_VALID ##1 !PDO_VALID && !r_reg.reload |-> MODE_OUT == $past(PDO_DATA.mode)
      ##1 CTRL_OUT == $past(PDO_DATA.ctrl, 2))
      else $error("mode and control order wrong");

   a_ttype_refused: assert property (
      TTYPE_VALID && TTYPE_VALUE == TTYPE_ASYNC_CYC |=> TTYPE_REJECT && $stable(TTYPE_OUT))
      else $error("asynchronous cyclic type accepted");

   a_emcy_stops: assert property (
      EMCY_RX_VALID && EMCY_RX_COBID == EMCY_RX_ID && EMCY_RX_CODE == EMCY_STOP_CODE
      |=> NMT_STATE == NMT_STOPPED)
      else $error("emergency stop code ignored");

   a_supply_err_reg: assert property (
      EMCY_TX_VALID && (EMCY_TX.code == EMCY_OV_CODE || EMCY_TX.code == EMCY_UV_CODE)
      |-> EMCY_TX.err_reg == ERR_REG_SUPPLY)
      else $error("supply emergency register wrong");

   a_react_exit: assert property (
      r_reg.st == ST_FAULT_REACT |=> r_reg.st == ST_WARN_PAUSE || r_reg.st == ST_LOCKOUT)
      else $error("reaction state not transient");
endmodule

// ### dv/vnss_master.sv
// network master model: steps node states and sends network commands
`timescale 1ns/10ps
module vnss_master
   import vnss_pkg::*;
(
   input wire logic clk, // node clock
   output logic req_v, // state request strobe
   output vnss_state_t req, // requested state
   output logic nmt_v, // network command strobe
   output vnss_ncmd_t nmt // network command
);
   // quiet bus from time zero
   initial begin
      {req_v, nmt_v} = 2'b00;
      req = ST_LOCKOUT;
      nmt = NCMD_STOP;
   end
   // no dead band or set point writes, so no range is ever left
   // one request per call, never overlapping
   task automatic go(input vnss_state_t s);
      @(posedge clk);
      req_v <= 1'b1;
      req <= s;
      @(posedge clk);
      req_v <= 1'b0;
      #1;
   endtask
   // one network command pulse
   task automatic cmd(input vnss_ncmd_t c);
      @(posedge clk);
      nmt_v <= 1'b1;
      nmt <= c;
      @(posedge clk);
      nmt_v <= 1'b0;
      #1;
   endtask
   // boot walk up to running
   task automatic bring_up();
      go(ST_SAFE_IDLE);
      go(ST_MODE_SELECT);
      go(ST_RUNNING);
   endtask
endmodule

// ### dv/valve_node_state_supervisor_test.sv
// self-checking bench for the valve node supervisor
`timescale 1ns/10ps
module valve_node_state_supervisor_test
   import vnss_pkg::*;
;
   logic REF_CLK, ARST_N, STATE_REQ_VALID, STATE_REQ_ACK, NMT_CMD_VALID, LSS_CMD_VALID;
   logic LSS_ACCEPT, LSS_REJECT, PDO_VALID, TTYPE_VALID, TTYPE_REJECT, ET_VALID, GUARD_EN;
   logic RPDO_RX, GUARD_TIMEOUT, EMCY_RX_VALID, SUPPLY_SAMPLE, OV_FAULT, UV_FAULT, fr;
   logic CRIT_FAULT, DEFAULTS_RELOAD, EMCY_TX_VALID, ev;
   logic [7:0] NODE_ID_PIN, MODE_OUT, TTYPE_VALUE, TTYPE_OUT;
   logic [15:0] NODE_STATUS_WORD, CTRL_OUT, ET_VALUE, GUARD_MS, EMCY_RX_CODE;
   logic [15:0] SUPPLY_A_MV, SUPPLY_B_MV;
   logic [10:0] EMCY_RX_COBID;
   logic [6:0] stb; // side strobes
   logic [15:0] et_in [5] = '{16'h0, 16'hFB, 16'hFA, 16'h1D, 16'h1}; // timer writes
   logic [15:0] et_exp [5] = '{16'h0, 16'hFA, 16'hFA, 16'h1E, 16'h1E}; // guard values
   vnss_state_t STATE_REQ, NODE_STATE;
   vnss_ncmd_t NMT_CMD;
   vnss_nmt_t NMT_STATE;
   vnss_pdo_t PDO_DATA;
   vnss_emcy_t EMCY_TX;
   int failures = 0, n_compared = 0, cyc = 0, n;
   localparam logic [6:0] S_LSS = 7'h40, S_PDO = 7'h20, S_TT = 7'h10, S_ET = 7'h08;
   localparam logic [6:0] S_RX = 7'h04, S_EM = 7'h02, S_SUP = 7'h01;
   assign {LSS_CMD_VALID, PDO_VALID, TTYPE_VALID, ET_VALID, RPDO_RX, EMCY_RX_VALID} = stb[6:1];
   assign SUPPLY_SAMPLE = stb[0];
   vnss_top #(.MS_CYC(10), .FLT_LIM(4)) uut (.*); // short counts
   vnss_master m (.clk(REF_CLK), .req_v(STATE_REQ_VALID), .req(STATE_REQ),
      .nmt_v(NMT_CMD_VALID), .nmt(NMT_CMD));
   // 25 MHz clock
   initial begin
      REF_CLK = 1'b0;
      forever #20 REF_CLK = ~REF_CLK;
   end
   // hang guard
   always @(posedge REF_CLK) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         failures++;
         complete_run();
      end
   end
   // compare and count
   task automatic chk(input logic [47:0] got, input logic [47:0] exp);
      n_compared++;
      if (got !== exp) begin
         failures++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // one strobe cycle; w and x carry the words of the strobed service
   task automatic put(input logic [6:0] s, input logic [15:0] w, input logic [15:0] x);
      @(posedge REF_CLK);
      stb <= s;
      {ET_VALUE, EMCY_RX_CODE, SUPPLY_A_MV, SUPPLY_B_MV} <= {w, w, w, x};
      {TTYPE_VALUE, EMCY_RX_COBID, PDO_DATA} <= {x[7:0], x[10:0], w, x[7:0]};
      @(posedge REF_CLK);
      stb <= 7'h00;
      #1;
   endtask
   // transient reaction state must show, then the given state
   task automatic settle(input vnss_state_t st, input logic e);
      fr = 1'b0;
      ev = 1'b0;
      repeat (4) begin
         fr = fr | (NODE_STATE === ST_FAULT_REACT);
         ev = ev | (EMCY_TX_VALID === 1'b1);
         @(posedge REF_CLK);
         #1;
      end
      chk({fr, ev, NODE_STATE}, {1'b1, e, st});
   endtask
   // refused move while pre-operational
   task automatic t_illegal();
      m.go(ST_SAFE_IDLE);
      chk(STATE_REQ_ACK, 1'b1);
      settle(ST_WARN_PAUSE, 1'b1);
      chk({EMCY_TX, NODE_STATUS_WORD}, 40'h520021_0000);
   endtask
   // legal walks, combined update, reload on startup
   task automatic t_run();
      m.cmd(NCMD_START);
      m.go(ST_MODE_SELECT);
      chk(NODE_STATE, ST_MODE_SELECT);
      m.cmd(NCMD_RESET_NODE);
      m.cmd(NCMD_START);
      m.bring_up();
      chk(NODE_STATUS_WORD, 16'h0003);
      put(S_PDO, 16'h1234, 16'h005A);
      chk({CTRL_OUT, MODE_OUT}, 24'h00005A);
      @(posedge REF_CLK);
      #1;
      chk({CTRL_OUT, MODE_OUT}, 24'h12345A);
      m.cmd(NCMD_RESET_NODE);
      fr = DEFAULTS_RELOAD;
      @(posedge REF_CLK);
      #1;
      chk({fr | DEFAULTS_RELOAD, NODE_STATE, CTRL_OUT, MODE_OUT}, {1'b1, ST_STARTUP, 24'h0});
   endtask
   // filtered supply faults, limits and saturation
   task automatic t_supply();
      repeat (6) put(S_SUP, 16'h2328, 16'h8AAC);
      chk({OV_FAULT, UV_FAULT}, 2'b00);
      repeat (3) put(S_SUP, 16'h2EE0, 16'h8AAD);
      chk(OV_FAULT, 1'b0);
      put(S_SUP, 16'h2EE0, 16'h8AAD);
      settle(ST_WARN_PAUSE, 1'b1);
      chk(EMCY_TX, 24'h341105);
      repeat (3) put(S_SUP, 16'h8AAD, 16'h2EE0);
      m.go(ST_MODE_SELECT);
      settle(ST_WARN_PAUSE, 1'b1);
      repeat (3) put(S_SUP, 16'h2EE0, 16'h2EE0);
      chk(OV_FAULT, 1'b1);
      put(S_SUP, 16'h2EE0, 16'h2EE0);
      chk(OV_FAULT, 1'b0);
      m.go(ST_MODE_SELECT);
      chk(NODE_STATE, ST_MODE_SELECT);
      repeat (4) put(S_SUP, 16'h2327, 16'h2EE0);
      settle(ST_WARN_PAUSE, 1'b1);
      chk(EMCY_TX, 24'h341205);
      repeat (4) put(S_SUP, 16'h2EE0, 16'h2EE0);
      chk(UV_FAULT, 1'b0);
   endtask
   // transmit type, timer clamps, guard expiry, emergency stop, layer setting
   task automatic t_services();
      put(S_TT, 16'h0, 16'h00FE);
      chk({TTYPE_REJECT, TTYPE_OUT}, 9'h101);
      put(S_TT, 16'h0, 16'h0005);
      chk({TTYPE_REJECT, TTYPE_OUT}, 9'h005);
      for (int i = 0; i < 5; i++) begin
         put(S_ET, et_in[i], 16'h0);
         chk({GUARD_EN, GUARD_MS}, {et_exp[i] != 16'h0, et_exp[i]});
      end
      put(S_RX, 16'h0, 16'h0);
      n = 0;
      while (GUARD_TIMEOUT !== 1'b1 && n < 400) begin
         @(posedge REF_CLK);
         #1;
         n++;
      end
      chk(n > 285 && n < 315, 1'b1);
      put(S_LSS, 16'h0, 16'h0);
      chk({LSS_ACCEPT, LSS_REJECT}, 2'b01);
      put(S_EM, 16'h1000, 16'h0082);
      chk(NMT_STATE === NMT_STOPPED, 1'b0);
      put(S_EM, 16'h1000, 16'h0081);
      chk(NMT_STATE, NMT_STOPPED);
      put(S_LSS, 16'h0, 16'h0);
      chk({LSS_ACCEPT, LSS_REJECT}, 2'b10);
   endtask
   // critical fault locks out for good
   task automatic t_lock();
      @(posedge REF_CLK);
      CRIT_FAULT <= 1'b1;
      #1;
      settle(ST_LOCKOUT, 1'b0);
      m.go(ST_SAFE_IDLE);
      repeat (3) @(posedge REF_CLK);
      #1;
      chk(NODE_STATE, ST_LOCKOUT);
   endtask
   // verdict and end of run
   task automatic complete_run();
      if (failures == 0 && n_compared > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // reset, then the scenarios in turn
   initial begin
      {ARST_N, CRIT_FAULT, stb, NODE_ID_PIN} = 17'h0_0005;
      {ET_VALUE, EMCY_RX_CODE, SUPPLY_A_MV, SUPPLY_B_MV} = 64'h0_2EE02EE0;
      {TTYPE_VALUE, EMCY_RX_COBID, PDO_DATA} = '0;
      repeat (10) @(posedge REF_CLK);
      #1;
      chk({DEFAULTS_RELOAD, TTYPE_OUT}, 9'h101);
      ARST_N = 1'b1;
      t_illegal();
      t_run();
      t_supply();
      t_services();
      t_lock();
      complete_run();
   end
endmodule
